/* tcc_pins.sv */
// Pin-side partner model: capture pins, count clock sources and cutoff input.
`timescale 1ns/1ps
module tcc_pins (
  input  wire logic       CLOCK,
  output logic      [3:0] CAP_PIN,
  output logic            SLOW_DIV128,
  output logic            EXT_CLK_PIN,
  output logic            FAST_OSC,
  output logic            FAST_OSC_ALT,
  output logic            CUTOFF_N
);
  logic [2:0] ph_q = 3'h0;
  // ==========================================================================
  // Clock sources run free: external clock period 8 cycles, fast ones 4.
  always @(posedge CLOCK) begin
    ph_q <= ph_q + 3'h1;
  end
  assign EXT_CLK_PIN  = ph_q[2];
  assign FAST_OSC     = ph_q[1];
  assign FAST_OSC_ALT = ph_q[1];
  // Pins start low and the cutoff input released.
  initial begin
    CAP_PIN     = 4'h0;
    SLOW_DIV128 = 1'b0;
    CUTOFF_N    = 1'b1;
  end
  // Sets all levels, then holds them 4 cycles so every edge is wide enough.
  task automatic drive(input logic [3:0] p, input logic s, input logic c);
    @(posedge CLOCK);
    CAP_PIN     <= p;
    SLOW_DIV128 <= s;
    CUTOFF_N    <= c;
    repeat (4) @(posedge CLOCK);
  endtask
endmodule

/* tcc_pkg.sv */
// Package of constants and state type for the four-channel capture/compare timer.
package tcc_pkg;
  // ==========================================================================
  // Register offsets.
  localparam logic [9:0] MODE_OFS  = 10'h120;
  localparam logic [9:0] CCR1_OFS  = 10'h121;
  localparam logic [9:0] IOR0_OFS  = 10'h124;
  localparam logic [9:0] IOR1_OFS  = 10'h125;
  localparam logic [9:0] COUNT_OFS = 10'h126;
  localparam logic [9:0] GRA_OFS   = 10'h128;
  localparam logic [9:0] GRB_OFS   = 10'h12A;
  localparam logic [9:0] GRC_OFS   = 10'h12C;
  localparam logic [9:0] GRD_OFS   = 10'h12E;
  localparam logic [9:0] CCR2_OFS  = 10'h130;
  localparam logic [9:0] OER_OFS   = 10'h132;
  // ==========================================================================
  // Reset values.
  localparam logic [7:0]  CCR1_RST = 8'h00;
  localparam logic [7:0]  IOR0_RST = 8'h88;
  localparam logic [7:0]  IOR1_RST = 8'h88;
  localparam logic [3:0]  OER_RST  = 4'hF;
  // ==========================================================================
  // Field positions.
  localparam int RUN_BIT  = 0;
  localparam int CBUF_BIT  = 1;
  localparam int DBUF_BIT  = 2;
  localparam int TCK_LSB   = 4;
  localparam int CLR_BIT   = 7;
  localparam int STOP_BIT  = 5;
  localparam int CUTEN_BIT = 7;
  localparam int SRCA_BIT = 3;
  localparam int FUNC_C_BIT = 11;
  localparam int FUNC_D_BIT = 15;
  // ==========================================================================
  // Count source codes and synchroniser lanes.
  localparam logic [2:0] TCK_DIV1 = 3'h0;
  localparam logic [2:0] TCK_DIV2 = 3'h1;
  localparam logic [2:0] TCK_DIV4 = 3'h2;
  localparam logic [2:0] TCK_DIV8 = 3'h3;
  localparam logic [2:0] TCK_DIV32 = 3'h4;
  localparam logic [2:0] TCK_EXT  = 3'h5;
  localparam logic [2:0] TCK_FAST = 3'h6;
  localparam logic [2:0] TCK_ALT  = 3'h7;
  localparam int NSYNC = 9;
  // ==========================================================================
  // Whole state of the timer.
  typedef struct packed {
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [NSYNC-1:0] sync3;
    logic [4:0]       pre;
    logic [15:0]      count;
    logic [3:0][15:0] gr;
    logic [7:0]       ccr1;
    logic [15:0]      io;
    logic             run;
    logic             buf_c;
    logic             buf_d;
    logic             stop_sel;
    logic             cut_en;
    logic [3:0]       oer;
    logic [3:0]       out;
    logic [3:0]       oe_n;
    logic [4:0]       irq;
    logic [15:0]      rdata;
  } tcc_state_t;
endpackage

/* tcc_timer.sv */
// Four-channel 16-bit capture/compare timer with register port.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
// Behaviour
// - Edge field picks rising, falling, both.
// - Channel A source: divided oscillator or pin.
// - Source switch matters only in capture mode.
// - I/O register 0 bit 7 reads one.
// - Unbuffered C, D capture own pins.
// - Buffered C, D follow A, B pins.
// - Compare match drives pin configured level.
// - Free run or clear on A match.
// - Three-bit field picks count source.
// - Run bit starts; stop holds the counter, captures still work.
// - Stop-on-match halts at A match.
// - Request on each match and overflow.
// - Initial level driven on control write.
// - Buffer holds next compare value.
// - Counter readable and writable anytime.
// - Compare field: none, low, high, toggle.
// - Buffer copied to A/B on match.
// - Capture moves old A/B into buffer.
// - Cutoff pin low disables all outputs.
module tcc_timer (
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic [9:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  input  wire logic [3:0]  CAP_PIN,
  input  wire logic        SLOW_DIV128,
  input  wire logic        EXT_CLK_PIN,
  input  wire logic        FAST_OSC,
  input  wire logic        FAST_OSC_ALT,
  input  wire logic        CUTOFF_N,
  output logic      [3:0]  PIN_OUT,
  output logic      [3:0]  PIN_OE_N,
  output logic      [4:0]  IRQ_REQ
);
  tcc_pkg::tcc_state_t q;
  tcc_pkg::tcc_state_t d;
  logic [tcc_pkg::NSYNC-1:0] rise;
  logic [tcc_pkg::NSYNC-1:0] fall;
  logic                      tick;
  logic [3:0]                cap_ev;
  logic [3:0]                match;
  logic                      ovf;
  logic                      cut;

  // ==========================================================================
  // Edge detection on synchronised inputs and count source selection.
  assign rise = q.sync2 & ~q.sync3;
  assign fall = ~q.sync2 & q.sync3;
  assign cut  = q.cut_en & ~q.sync2[8];

  // Picks the count tick from the prescaler or a sampled clock.
  always_comb begin
    case (q.ccr1[tcc_pkg::TCK_LSB +: 3])
      tcc_pkg::TCK_DIV1:  tick = 1'b1;
      tcc_pkg::TCK_DIV2:  tick = q.pre[0];
      tcc_pkg::TCK_DIV4:  tick = &q.pre[1:0];
      tcc_pkg::TCK_DIV8:  tick = &q.pre[2:0];
      tcc_pkg::TCK_DIV32: tick = &q.pre[4:0];
      tcc_pkg::TCK_EXT:   tick = rise[5];
      tcc_pkg::TCK_FAST:  tick = rise[6];
      tcc_pkg::TCK_ALT:   tick = rise[7];
      default:            tick = 1'b0;
    endcase
  end

  assign ovf = q.run & tick & (q.count == 16'hFFFF) & ~(match[0] & q.ccr1[tcc_pkg::CLR_BIT]);

  // ==========================================================================
  // Per-channel capture event and compare match.
  for (genvar j = 0; j < 4; j++) begin : g_ch
    logic [1:0] ef;
    logic       r;
    logic       f;
    assign ef = q.io[4*j +: 2];
    // Channel A may sample the divided oscillator instead of its pin.
    if (j == 0) begin : g_src
      assign r = q.io[tcc_pkg::SRCA_BIT] ? rise[0] : rise[4];
      assign f = q.io[tcc_pkg::SRCA_BIT] ? fall[0] : fall[4];
    end else begin : g_pin
      assign r = rise[j];
      assign f = fall[j];
    end
    assign cap_ev[j] = q.io[4*j+2] & (((ef == 2'h0) & r) | ((ef == 2'h1) & f) |
                                      ((ef == 2'h2) & (r | f)));
    assign match[j]  = q.run & tick & ~q.io[4*j+2] & (q.count == q.gr[j]);
  end

  // ==========================================================================
  // Next-state logic for the whole timer.
  always_comb begin
    logic [1:0] tp;
    d = q;
    tp = 2'h0;
    d.sync1 = {CUTOFF_N, FAST_OSC_ALT, FAST_OSC, EXT_CLK_PIN, SLOW_DIV128, CAP_PIN};
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    d.pre   = q.pre + 5'h01;
    d.irq   = {ovf, cap_ev | match};
    d.rdata = 16'h0000;
    // Counter advance, clear and automatic stop.
    if (q.run && tick) begin
      if (match[0] && q.ccr1[tcc_pkg::CLR_BIT]) d.count = 16'h0000;
      else if (!(match[0] && q.stop_sel)) d.count = q.count + 16'h0001;
    end
    // Stop-on-match leaves the counter on the matched value unless clear-on-match clears it.
    if (match[0] && q.stop_sel) d.run = 1'b0;
    // Pin action on compare match; C and D may steer pins A and B.
    for (int j = 0; j < 4; j++) begin
      tp = 2'(j);
      if (j == 2) tp = q.io[tcc_pkg::FUNC_C_BIT] ? 2'h2 : 2'h0;
      if (j == 3) tp = q.io[tcc_pkg::FUNC_D_BIT] ? 2'h3 : 2'h1;
      if (match[j] && !(j == 2 && q.buf_c) && !(j == 3 && q.buf_d)) begin
        case (q.io[4*j +: 2])
          2'h1:    d.out[tp] = 1'b0;
          2'h2:    d.out[tp] = 1'b1;
          2'h3:    d.out[tp] = ~q.out[tp];
          default: d.out[tp] = d.out[tp];
        endcase
      end
    end
    // Buffered compare loads the next value.
    if (match[0] && q.buf_c) d.gr[0] = q.gr[2];
    if (match[1] && q.buf_d) d.gr[1] = q.gr[3];
    // Software writes.
    if (WR) begin
      case (ADDR)
        tcc_pkg::MODE_OFS: begin
          d.run = WDATA[tcc_pkg::RUN_BIT];
          d.buf_c = WDATA[tcc_pkg::CBUF_BIT];
          d.buf_d = WDATA[tcc_pkg::DBUF_BIT];
          if (!q.run && WDATA[tcc_pkg::RUN_BIT]) d.out = q.ccr1[3:0];
        end
        tcc_pkg::CCR1_OFS: begin
          d.ccr1 = WDATA[7:0];
          d.out  = WDATA[3:0];
        end
        tcc_pkg::IOR0_OFS:  d.io[6:0]  = WDATA[6:0];
        tcc_pkg::IOR1_OFS:  d.io[15:8] = WDATA[7:0];
        tcc_pkg::CCR2_OFS:  d.stop_sel = WDATA[tcc_pkg::STOP_BIT];
        tcc_pkg::COUNT_OFS: d.count = WDATA;
        tcc_pkg::GRA_OFS:   d.gr[0] = WDATA;
        tcc_pkg::GRB_OFS:   d.gr[1] = WDATA;
        tcc_pkg::GRC_OFS:   d.gr[2] = WDATA;
        tcc_pkg::GRD_OFS:   d.gr[3] = WDATA;
        tcc_pkg::OER_OFS: begin
          d.oer = WDATA[3:0];
          d.cut_en = WDATA[tcc_pkg::CUTEN_BIT];
        end
        default: d.run = d.run;
      endcase
    end
    // Captures come after writes so they win a collision.
    if (cap_ev[0]) begin
      if (q.buf_c) d.gr[2] = q.gr[0];
      d.gr[0] = q.count;
    end
    if (cap_ev[1]) begin
      if (q.buf_d) d.gr[3] = q.gr[1];
      d.gr[1] = q.count;
    end
    if (cap_ev[2] && !q.buf_c) d.gr[2] = q.count;
    if (cap_ev[3] && !q.buf_d) d.gr[3] = q.count;
    // Forced cutoff overrides any write to the disable bits.
    if (cut) d.oer = 4'hF;
    for (int j = 0; j < 4; j++) begin
      d.oe_n[j] = ~(~d.io[4*j+2] & (d.io[4*j +: 2] != 2'h0) & ~d.oer[j]);
    end
    // Read data for the next cycle.
    if (RD) begin
      case (ADDR)
        tcc_pkg::MODE_OFS:  d.rdata = {13'h0000, q.buf_d, q.buf_c, q.run};
        tcc_pkg::CCR1_OFS:  d.rdata = {8'h00, q.ccr1};
        tcc_pkg::IOR0_OFS:  d.rdata = {8'h00, 1'b1, q.io[6:0]};
        tcc_pkg::IOR1_OFS:  d.rdata = {8'h00, q.io[15:8]};
        tcc_pkg::CCR2_OFS:  d.rdata = {10'h000, q.stop_sel, 5'h18};
        tcc_pkg::COUNT_OFS: d.rdata = q.count;
        tcc_pkg::GRA_OFS:   d.rdata = q.gr[0];
        tcc_pkg::GRB_OFS:   d.rdata = q.gr[1];
        tcc_pkg::GRC_OFS:   d.rdata = q.gr[2];
        tcc_pkg::GRD_OFS:   d.rdata = q.gr[3];
        tcc_pkg::OER_OFS:   d.rdata = {8'h00, q.cut_en, 3'h0, q.oer};
        default:            d.rdata = 16'h0000;
      endcase
    end
  end

  // Registers the state; reset loads the documented values.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      q      <= '0;
      q.ccr1 <= tcc_pkg::CCR1_RST;
      q.io   <= {tcc_pkg::IOR1_RST, tcc_pkg::IOR0_RST};
      q.oer  <= tcc_pkg::OER_RST;
      q.oe_n <= 4'hF;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the state flops.
  assign RDATA    = q.rdata;
  assign PIN_OUT  = q.out;
  assign PIN_OE_N = q.oe_n;
  assign IRQ_REQ  = q.irq;

  // ==========================================================================
  // Assertions and covers.
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  edge_rise_a: assert property (q.io[2] && q.io[1:0] == 2'h0 && q.io[3] && rise[0]
    |-> cap_ev[0]) else $error("rising edge on A not captured");
  src_osc_a: assert property (q.io[2] && !q.io[3] && q.io[1:0] == 2'h0
    && rise[4] && !rise[0] |-> cap_ev[0]) else $error("oscillator capture missed");
  cap_value_a: assert property (cap_ev[0] |=> q.gr[0] == $past(q.count))
    else $error("channel A capture value wrong");
  buf_move_a: assert property (cap_ev[0] && q.buf_c |=> q.gr[2] == $past(q.gr[0]))
    else $error("old A value not moved to buffer");
  own_pin_a: assert property (cap_ev[2] && !q.buf_c && !WR |=> q.gr[2] == $past(q.count))
    else $error("channel C own capture wrong");
  fixed_bit_a: assert property (RD && ADDR == tcc_pkg::IOR0_OFS |=> RDATA[7])
    else $error("bit 7 not read as one");
  clear_match_a: assert property (match[0] && q.ccr1[7] && !WR |=> q.count == 16'h0000)
    else $error("counter not cleared on A match");
  stop_match_a: assert property (match[0] && q.stop_sel && !WR |=> !q.run ##1 !q.run)
    else $error("count did not stop on A match");
  hold_stop_a: assert property (!q.run && !WR |=> $stable(q.count))
    else $error("counter moved while stopped");
  drive_low_a: assert property (match[1] && q.io[5:4] == 2'h1 && !match[3] && !WR
    |=> !PIN_OUT[1]) else $error("pin B not driven low");
  match_irq_a: assert property (match[1] |=> IRQ_REQ[1])
    else $error("no request on B match");
  ovf_irq_a: assert property (ovf |=> IRQ_REQ[4] ##1 q.count != 16'hFFFF || !q.run)
    else $error("no request on overflow");
  cutoff_a: assert property (cut |=> q.oer == 4'hF ##1 PIN_OE_N == 4'hF)
    else $error("cutoff did not disable outputs");
  buf_load_a: assert property (match[0] && q.buf_c && !cap_ev[0] && !WR
    |=> q.gr[0] == $past(q.gr[2])) else $error("buffer not loaded into A");

  // ==========================================================================
  // Further checks on counting, levels and the read port.
  // The counter sits on the matched value when stop-on-match ends a run without clear-on-match.
  hold_match_a: assert property (match[0] && q.stop_sel && !q.ccr1[7] && !WR
    |=> q.count == $past(q.count)) else $error("counter moved past stop match");
  // A plain tick adds exactly one.
  count_step_a: assert property (q.run && tick && !match[0] && !WR
    |=> q.count == $past(q.count) + 16'h0001) else $error("counter step wrong");
  // The undivided source ticks on every clock.
  div_one_a: assert property (q.ccr1[6:4] == 3'h0 |-> tick)
    else $error("divide-by-one source idle");
  // A compare channel never captures, whatever its source switch says.
  src_ignore_a: assert property (!q.io[2] |-> !cap_ev[0])
    else $error("compare channel A captured");
  // The forbidden edge code never captures.
  bad_code_a: assert property (q.io[1:0] == 2'h3 |-> !cap_ev[0])
    else $error("forbidden edge code captured");
  // Writing the level register shows the levels at once.
  init_level_a: assert property (WR && ADDR == tcc_pkg::CCR1_OFS
    |=> PIN_OUT == $past(WDATA[3:0])) else $error("initial levels not driven");
  // Toggle action inverts pin A when channel C drives its own pin.
  toggle_a: assert property (match[0] && q.io[1:0] == 2'h3 && q.io[11] && !WR
    |=> PIN_OUT[0] != $past(PIN_OUT[0])) else $error("pin A did not toggle");
  // A run bit write starts the counter.
  run_start_a: assert property (WR && ADDR == tcc_pkg::MODE_OFS && WDATA[0]
    |=> q.run) else $error("run bit write ignored");
  // Read data stand for one cycle only.
  rdata_idle_a: assert property (!RD |=> RDATA == 16'h0000)
    else $error("read data outside read cycle");

  cap_buf_c: cover property (cap_ev[0] && q.buf_c);
  stop_c: cover property (match[0] && q.stop_sel);
  cmp_clr_c: cover property (match[0] && q.ccr1[7]);
  cut_c: cover property (cut ##1 q.oer == 4'hF);
  ovf_c: cover property (ovf);
endmodule

/* timer_capture_compare_channels_bench.sv */
// Self-checking bench for the four-channel capture/compare timer.
`timescale 1ns/1ps
module timer_capture_compare_channels_bench;
  logic        clock = 1'b0;
  logic        rst   = 1'b1;
  logic        wr_s  = 1'b0;
  logic        rd_s  = 1'b0;
  logic [9:0]  addr  = 10'h000;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata, v, g, h;
  logic [3:0]  cap, pin_out, oe_n;
  logic [4:0]  irq;
  logic        slow, ext, fast, alt, cut_n;
  int          miscompares = 0;
  int          check_count = 0;
  int          irq_a = 0;
  int          n0;
  int          ex[8] = '{66, 33, 16, 8, 2, 8, 16, 16};
  // ==========================================================================
  // Clock, request counter and instances.
  always #4 clock = ~clock;
  // Counts request pulses of channel A.
  always @(posedge clock) if (irq[0] === 1'b1) irq_a <= irq_a + 1;
  tcc_pins i_pins (.CLOCK(clock), .CAP_PIN(cap), .SLOW_DIV128(slow), .EXT_CLK_PIN(ext),
    .FAST_OSC(fast), .FAST_OSC_ALT(alt), .CUTOFF_N(cut_n));
  tcc_timer i_dut (.CLOCK(clock), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
    .RD(rd_s), .RDATA(rdata), .CAP_PIN(cap), .SLOW_DIV128(slow), .EXT_CLK_PIN(ext),
    .FAST_OSC(fast), .FAST_OSC_ALT(alt), .CUTOFF_N(cut_n), .PIN_OUT(pin_out),
    .PIN_OE_N(oe_n), .IRQ_REQ(irq));
  // ==========================================================================
  // Register bus tasks and comparisons.
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clock);
    wr_s  <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [9:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rng(input string nm, input int lo, input int hi, input logic [15:0] s);
    check_count++;
    if ((^s === 1'bx) || s < lo || s > hi) begin
      miscompares++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, s);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence.
  initial begin
    void'($urandom(32'hDABE));
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    // Reset values, the read-one bit and an unmapped address.
    rd(tcc_pkg::CCR1_OFS, g); chk("ctrl1", 16'h0000, g);
    rd(tcc_pkg::IOR1_OFS, g); chk("io1", 16'h0088, g);
    wr(tcc_pkg::IOR0_OFS, 16'h0000);
    rd(tcc_pkg::IOR0_OFS, g); chk("io0", 16'h0080, g);
    wr(10'h3FF, 16'hFFFF);
    rd(10'h3FF, g); chk("unmapped", 16'h0000, g);
    v = 16'($urandom());
    wr(tcc_pkg::COUNT_OFS, v);
    rd(tcc_pkg::COUNT_OFS, g); chk("counter", v, g);
    $display("registers done");
    // Capture on channel A pin for the rising, falling and both edge codes; counter is stopped.
    for (int c = 0; c < 3; c++) begin
      wr(tcc_pkg::IOR0_OFS, 16'h000C | 16'(c));
      v = 16'($urandom());
      wr(tcc_pkg::COUNT_OFS, v);
      n0 = irq_a;
      i_pins.drive(4'h1, 1'b0, 1'b1);
      i_pins.drive(4'h0, 1'b0, 1'b1);
      rd(tcc_pkg::GRA_OFS, g); chk("capture A", v, g);
      rng("capture count", (c == 2) ? 2 : 1, (c == 2) ? 2 : 1, 16'(irq_a - n0));
    end
    // Oscillator source: pin edges ignored, divided oscillator edge captured.
    wr(tcc_pkg::IOR0_OFS, 16'h0004);
    v = 16'($urandom());
    wr(tcc_pkg::COUNT_OFS, v);
    n0 = irq_a;
    i_pins.drive(4'h1, 1'b0, 1'b1);
    i_pins.drive(4'h0, 1'b1, 1'b1);
    i_pins.drive(4'h0, 1'b0, 1'b1);
    rng("osc capture", 1, 1, 16'(irq_a - n0));
    rd(tcc_pkg::GRA_OFS, g); chk("osc capture A", v, g);
    // Buffered C: old A moves into C, then A takes the counter.
    wr(tcc_pkg::MODE_OFS, 16'h0002);
    wr(tcc_pkg::IOR0_OFS, 16'h000C);
    wr(tcc_pkg::IOR1_OFS, 16'h008C);
    g = 16'($urandom());
    wr(tcc_pkg::COUNT_OFS, g);
    i_pins.drive(4'h1, 1'b0, 1'b1);
    i_pins.drive(4'h0, 1'b0, 1'b1);
    rd(tcc_pkg::GRC_OFS, h); chk("buffer C", v, h);
    rd(tcc_pkg::GRA_OFS, h); chk("buffered A", g, h);
    // Unbuffered C captures on its own pin and leaves A alone.
    wr(tcc_pkg::MODE_OFS, 16'h0000);
    v = 16'($urandom());
    wr(tcc_pkg::COUNT_OFS, v);
    i_pins.drive(4'h4, 1'b0, 1'b1);
    i_pins.drive(4'h0, 1'b0, 1'b1);
    rd(tcc_pkg::GRC_OFS, h); chk("own C", v, h);
    rd(tcc_pkg::GRA_OFS, h); chk("A kept", g, h);
    $display("capture done");
    // Every count source over a fixed run window; counter holds after stop.
    wr(tcc_pkg::IOR0_OFS, 16'h0000);
    wr(tcc_pkg::IOR1_OFS, 16'h0088);
    for (int k = 0; k < 8; k++) begin
      wr(tcc_pkg::CCR1_OFS, 16'(k) << 4);
      wr(tcc_pkg::COUNT_OFS, 16'h0000);
      wr(tcc_pkg::MODE_OFS, 16'h0001);
      repeat (64) @(posedge clock);
      wr(tcc_pkg::MODE_OFS, 16'h0000);
      rd(tcc_pkg::COUNT_OFS, v); rng("source count", ex[k] - 2, ex[k] + 2, v);
      repeat (20) @(posedge clock);
      rd(tcc_pkg::COUNT_OFS, g); chk("stopped count", v, g);
    end
    $display("sources done");
    // Initial level, then a high-on-match compare with stop at the A match.
    wr(tcc_pkg::OER_OFS, 16'h0000);
    wr(tcc_pkg::IOR0_OFS, 16'h0002);
    wr(tcc_pkg::CCR1_OFS, 16'h0001);
    #1 chk("initial high", 16'h0001, {15'h0, pin_out[0]});
    wr(tcc_pkg::CCR1_OFS, 16'h0000);
    #1 chk("initial low", 16'h0000, {15'h0, pin_out[0]});
    v = 16'h0010 + 16'($urandom_range(200));
    wr(tcc_pkg::GRA_OFS, v);
    wr(tcc_pkg::CCR2_OFS, 16'h0020);
    wr(tcc_pkg::COUNT_OFS, 16'h0000);
    n0 = irq_a;
    wr(tcc_pkg::MODE_OFS, 16'h0001);
    for (int t = 0; t < 300 && pin_out[0] !== 1'b1; t++) @(posedge clock);
    #1 chk("match level", 16'h0001, {15'h0, pin_out[0]});
    repeat (10) @(posedge clock);
    rd(tcc_pkg::COUNT_OFS, g); chk("stop on match", v, g);
    rng("match request", 1, 1, 16'(irq_a - n0));
    chk("pin driven", 16'h0000, {15'h0, oe_n[0]});
    $display("compare done");
    // Forced cutoff turns every output off.
    wr(tcc_pkg::OER_OFS, 16'h0080);
    i_pins.drive(4'h0, 1'b0, 1'b0);
    chk("cutoff pins", 16'h000F, {12'h0, oe_n});
    rd(tcc_pkg::OER_OFS, g); chk("cutoff bits", 16'h000F, g & 16'h000F);
    $display("cutoff done");
    give_verdict();
  end
endmodule
